// ---- tgw_defines.svh ----
// Register offsets, reset values and widths of the window position bank
`ifndef TGW_DEFINES_SVH
`define TGW_DEFINES_SVH
`define TGW_ADDR_W 8
`define TGW_DATA_W 24
`define TGW_POS_W 16
`define TGW_ADDR_ILLUM_START 8'h8F
`define TGW_ADDR_ILLUM_END 8'h90
`define TGW_ADDR_CALC_START 8'h91
`define TGW_ADDR_CALC_END 8'h92
`define TGW_ADDR_PDN_START 8'h93
`define TGW_ADDR_PDN_END 8'h94
`define TGW_RST_ILLUM_START 16'h0000
`define TGW_RST_ILLUM_END 16'h2134
`define TGW_RST_CALC_START 16'h2134
`define TGW_RST_CALC_END 16'h2EE0
`define TGW_RST_PDN_START 16'h0000
`define TGW_RST_PDN_END 16'hFFFF
`define TGW_POS_ZERO 16'h0000
`define TGW_POS_STEP 16'h0001
`define TGW_RSVD_ZERO 8'h00
`define TGW_NUM_WIN 3
`endif

// ---- tgw_pkg.sv ----
// Types shared by the window generator
package tgw_pkg;
  typedef enum logic [2:0] {
    TGW_SEL_NONE,
    TGW_SEL_ILLUM_START,
    TGW_SEL_ILLUM_END,
    TGW_SEL_CALC_START,
    TGW_SEL_CALC_END,
    TGW_SEL_PDN_START,
    TGW_SEL_PDN_END
  } tgw_sel_t;
endpackage

// ---- tgw_window_cmp.sv ----
// One window comparator with a registered output
`timescale 1ns/1ps
`include "tgw_defines.svh"
module tgw_window_cmp #(
  parameter int POS_W = `TGW_POS_W
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [POS_W-1:0] pos,
  input wire logic [POS_W-1:0] start_pos,
  input wire logic [POS_W-1:0] end_pos,
  output logic active
);
  logic next_active;

  // Start inclusive, end exclusive; start at or past end gives no window
  always_comb begin
    next_active = (pos >= start_pos) && (pos < end_pos);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      active <= 1'b0;
    end else begin
      active <= next_active;
    end
  end
endmodule

// ---- tgw_window_gen.sv ----
// Sub-frame window generator: position counter, position registers, three windows
`timescale 1ns/1ps
`include "tgw_defines.svh"
// Summary of operation
// - Illumination enable window ends at a 16-bit programmable position, reset 2134h.
// - Calculation window begins at a 16-bit programmable position, reset 2134h.
// - Calculation window ends at a 16-bit programmable position, reset 2EE0h.
// - Power-down window begins at a 16-bit programmable position, reset zero.
// - Power-down window ends at a 16-bit programmable position, reset FFFFh.
// - Illumination enable window begins at a 16-bit programmable position, reset zero.
module tgw_window_gen
  import tgw_pkg::*;
#(
  parameter int ADDR_W = `TGW_ADDR_W,
  parameter int DATA_W = `TGW_DATA_W,
  parameter int POS_W = `TGW_POS_W
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic subframe_start,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata,
  output logic [POS_W-1:0] subframe_pos,
  output logic illum_window,
  output logic calc_window,
  output logic powerdown_window
);
  logic [POS_W-1:0] illum_window_start;
  logic [POS_W-1:0] illum_window_end;
  logic [POS_W-1:0] calc_window_start;
  logic [POS_W-1:0] calc_window_end;
  logic [POS_W-1:0] powerdown_window_start;
  logic [POS_W-1:0] powerdown_window_end;
  logic [POS_W-1:0] next_illum_window_start;
  logic [POS_W-1:0] next_illum_window_end;
  logic [POS_W-1:0] next_calc_window_start;
  logic [POS_W-1:0] next_calc_window_end;
  logic [POS_W-1:0] next_powerdown_window_start;
  logic [POS_W-1:0] next_powerdown_window_end;
  logic [DATA_W-1:0] next_reg_rdata;
  logic [POS_W-1:0] next_subframe_pos;
  logic [POS_W-1:0] win_start [`TGW_NUM_WIN];
  logic [POS_W-1:0] win_end [`TGW_NUM_WIN];
  logic [`TGW_NUM_WIN-1:0] win_active;
  tgw_sel_t wr_sel;
  tgw_sel_t rd_sel;
  logic [POS_W-1:0] rd_field;

  function automatic tgw_sel_t decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      `TGW_ADDR_ILLUM_START: decode = TGW_SEL_ILLUM_START;
      `TGW_ADDR_ILLUM_END: decode = TGW_SEL_ILLUM_END;
      `TGW_ADDR_CALC_START: decode = TGW_SEL_CALC_START;
      `TGW_ADDR_CALC_END: decode = TGW_SEL_CALC_END;
      `TGW_ADDR_PDN_START: decode = TGW_SEL_PDN_START;
      `TGW_ADDR_PDN_END: decode = TGW_SEL_PDN_END;
      default: decode = TGW_SEL_NONE;
    endcase
  endfunction

  // Register bank: only the low 16 bits are stored, so stray upper write bits are dropped
  always_comb begin
    wr_sel = decode(reg_addr);
    next_illum_window_start = illum_window_start;
    next_illum_window_end = illum_window_end;
    next_calc_window_start = calc_window_start;
    next_calc_window_end = calc_window_end;
    next_powerdown_window_start = powerdown_window_start;
    next_powerdown_window_end = powerdown_window_end;
    if (reg_we) begin
      case (wr_sel)
        TGW_SEL_ILLUM_START: next_illum_window_start = reg_wdata[POS_W-1:0];
        TGW_SEL_ILLUM_END: next_illum_window_end = reg_wdata[POS_W-1:0];
        TGW_SEL_CALC_START: next_calc_window_start = reg_wdata[POS_W-1:0];
        TGW_SEL_CALC_END: next_calc_window_end = reg_wdata[POS_W-1:0];
        TGW_SEL_PDN_START: next_powerdown_window_start = reg_wdata[POS_W-1:0];
        TGW_SEL_PDN_END: next_powerdown_window_end = reg_wdata[POS_W-1:0];
        default: next_illum_window_start = illum_window_start;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      illum_window_start <= `TGW_RST_ILLUM_START;
      illum_window_end <= `TGW_RST_ILLUM_END;
      calc_window_start <= `TGW_RST_CALC_START;
      calc_window_end <= `TGW_RST_CALC_END;
      powerdown_window_start <= `TGW_RST_PDN_START;
      powerdown_window_end <= `TGW_RST_PDN_END;
    end else begin
      illum_window_start <= next_illum_window_start;
      illum_window_end <= next_illum_window_end;
      calc_window_start <= next_calc_window_start;
      calc_window_end <= next_calc_window_end;
      powerdown_window_start <= next_powerdown_window_start;
      powerdown_window_end <= next_powerdown_window_end;
    end
  end

  // Read port: data registered one cycle after reg_re, unmapped reads return zero
  always_comb begin
    rd_sel = decode(reg_addr);
    case (rd_sel)
      TGW_SEL_ILLUM_START: rd_field = illum_window_start;
      TGW_SEL_ILLUM_END: rd_field = illum_window_end;
      TGW_SEL_CALC_START: rd_field = calc_window_start;
      TGW_SEL_CALC_END: rd_field = calc_window_end;
      TGW_SEL_PDN_START: rd_field = powerdown_window_start;
      TGW_SEL_PDN_END: rd_field = powerdown_window_end;
      default: rd_field = `TGW_POS_ZERO;
    endcase
    next_reg_rdata = reg_rdata;
    if (reg_re) begin
      next_reg_rdata = {`TGW_RSVD_ZERO, rd_field};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= {`TGW_RSVD_ZERO, `TGW_POS_ZERO};
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Position counter; wraps at full scale if no sub-frame restart arrives
  always_comb begin
    if (subframe_start) begin
      next_subframe_pos = `TGW_POS_ZERO;
    end else begin
      next_subframe_pos = subframe_pos + `TGW_POS_STEP;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      subframe_pos <= `TGW_POS_ZERO;
    end else begin
      subframe_pos <= next_subframe_pos;
    end
  end

  assign win_start[0] = illum_window_start;
  assign win_end[0] = illum_window_end;
  assign win_start[1] = calc_window_start;
  assign win_end[1] = calc_window_end;
  assign win_start[2] = powerdown_window_start;
  assign win_end[2] = powerdown_window_end;

  // Comparators look at the next count so each window lines up with subframe_pos
  for (genvar i = 0; i < `TGW_NUM_WIN; i++) begin : g_win
    tgw_window_cmp #(
      .POS_W(POS_W)
    ) u_cmp (
      .core_clk(core_clk),
      .srst(srst),
      .pos(next_subframe_pos),
      .start_pos(win_start[i]),
      .end_pos(win_end[i]),
      .active(win_active[i])
    );
  end

  assign illum_window = win_active[0];
  assign calc_window = win_active[1];
  assign powerdown_window = win_active[2];
endmodule

// ---- tgw_window_gen_properties.sv ----
// Port checks for the window generator
`timescale 1ns/1ps
module tgw_window_gen_properties (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic subframe_start,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [23:0] reg_rdata,
  input wire logic [15:0] subframe_pos,
  input wire logic illum_window,
  input wire logic calc_window,
  input wire logic powerdown_window
);
  logic [15:0] sh [6];
  logic [1:0] quiet;
  logic [7:0] idx;
  assign idx = reg_addr - 8'h8F;
  // Shadow copies; window checks wait out the compare lag after a write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sh <= '{16'h0000, 16'h2134, 16'h2134, 16'h2EE0, 16'h0000, 16'hFFFF};
      quiet <= 2'h0;
    end else begin
      if (reg_we && idx < 8'h06) sh[idx] <= reg_wdata[15:0];
      quiet <= reg_we ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence wr_s; reg_we && !reg_re && reg_addr inside {[8'h8F:8'h94]}; endsequence
  sequence rd_s; reg_re && !reg_we && $stable(reg_addr); endsequence
  pos_restart_a: assert property (subframe_start |=> subframe_pos == 16'h0000) else $error("no restart");
  pos_step_a: assert property (!subframe_start |=> subframe_pos == $past(subframe_pos) + 16'h0001)
    else $error("position did not advance");
  upper_zero_a: assert property (reg_rdata[23:16] == 8'h00) else $error("upper bits not zero");
  unmapped_read_a: assert property (reg_re && !(reg_addr inside {[8'h8F:8'h94]}) |=> reg_rdata == 24'h0)
    else $error("unmapped read not zero");
  write_readback_a: assert property (wr_s ##1 rd_s |=> reg_rdata == ($past(reg_wdata, 2) & 24'h00FFFF))
    else $error("readback mismatch");
  illum_win_a: assert property (quiet == 2'h3 |-> illum_window == (sh[0] <= subframe_pos && subframe_pos < sh[1]))
    else $error("illum window wrong");
  calc_win_a: assert property (quiet == 2'h3 |-> calc_window == (sh[2] <= subframe_pos && subframe_pos < sh[3]))
    else $error("calc window wrong");
  pdn_win_a: assert property (quiet == 2'h3 |-> powerdown_window == (sh[4] <= subframe_pos && subframe_pos < sh[5]))
    else $error("powerdown window wrong");
endmodule

// ---- tgw_window_gen_test.sv ----
// Self-checking bench for the window generator
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tgw_window_gen_test;
  logic core_clk = 1'b0, srst = 1'b1, subframe_start = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000, reg_rdata;
  logic [15:0] subframe_pos;
  logic illum_window, calc_window, powerdown_window;
  int failures = 0, check_count = 0;
  always #20 core_clk = ~core_clk;
  tgw_window_gen tgw_window_gen_inst (.core_clk(core_clk), .srst(srst), .subframe_start(subframe_start),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .subframe_pos(subframe_pos), .illum_window(illum_window), .calc_window(calc_window),
    .powerdown_window(powerdown_window));
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge core_clk);
    reg_we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    @(negedge core_clk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge core_clk);
    reg_re = 1'b0;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic reset_values();
    rd(8'h8F, 24'h000000);
    rd(8'h90, 24'h002134);
    rd(8'h91, 24'h002134);
    rd(8'h92, 24'h002EE0);
    rd(8'h93, 24'h000000);
    rd(8'h94, 24'h00FFFF);
  endtask
  task automatic upper_bits();
    // Software keeps reserved bits zero; they must still read back zero
    wr(8'h92, 24'h001234);
    rd(8'h92, 24'h001234);
    wr(8'h95, 24'h00ABCD);
    rd(8'h95, 24'h000000);
  endtask
  task automatic windows();
    int i;
    wr(8'h8F, 24'h000005);
    wr(8'h90, 24'h000008);
    wr(8'h91, 24'h000008);
    wr(8'h92, 24'h00000A);
    wr(8'h93, 24'h000001);
    wr(8'h94, 24'h000003);
    @(negedge core_clk);
    subframe_start = 1'b1;
    @(negedge core_clk);
    subframe_start = 1'b0;
    for (i = 0; i < 12; i++) begin
      `CHK("subframe_pos", i[15:0], subframe_pos)
      `CHK("illum_window", (i >= 5 && i < 8), illum_window)
      `CHK("calc_window", (i >= 8 && i < 10), calc_window)
      `CHK("powerdown_window", (i >= 1 && i < 3), powerdown_window)
      @(negedge core_clk);
    end
    subframe_start = 1'b1;
    @(negedge core_clk);
    subframe_start = 1'b0;
    `CHK("subframe_pos", 16'h0000, subframe_pos)
  endtask
  task automatic write_read_back();
    // Write then read with no idle cycle, then a write and read in one cycle
    @(negedge core_clk);
    reg_addr = 8'h91;
    reg_wdata = 24'h000100;
    reg_we = 1'b1;
    @(negedge core_clk);
    reg_we = 1'b0;
    reg_re = 1'b1;
    @(negedge core_clk);
    reg_re = 1'b0;
    `CHK("reg_rdata", 24'h000100, reg_rdata)
    @(negedge core_clk);
    reg_wdata = 24'h000200;
    reg_we = 1'b1;
    reg_re = 1'b1;
    @(negedge core_clk);
    reg_we = 1'b0;
    reg_re = 1'b0;
    `CHK("reg_rdata", 24'h000100, reg_rdata)
    rd(8'h91, 24'h000200);
  endtask
  task automatic mid_reset();
    // Reset in mid-run must bring every position back to its default
    @(negedge core_clk);
    srst = 1'b1;
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    reset_values();
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    reset_values();
    upper_bits();
    windows();
    write_read_back();
    mid_reset();
    final_report();
  end
  // Watchdog so a stuck run still reaches the verdict
  initial begin
    #200000;
    failures++;
    final_report();
  end
endmodule
bind tgw_window_gen tgw_window_gen_properties tgw_window_gen_properties_inst (.core_clk(core_clk), .srst(srst),
  .subframe_start(subframe_start), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .subframe_pos(subframe_pos), .illum_window(illum_window), .calc_window(calc_window),
  .powerdown_window(powerdown_window));
